// ---- pkg/fsr_pkg.sv ----
package fsr_pkg;

  // Bit period measured in system clock cycles (200 MHz clock, 1 to 10 MHz bit rate).
  localparam int LEN_W = 8;
  localparam logic [LEN_W-1:0] BIT_LEN_RESET = 8'h28;
  localparam logic [LEN_W-1:0] BIT_LEN_MAX = 8'hFF;

  // Timing counts in bit times or transmit clock periods.
  localparam logic [4:0] TRAIN_BIT_TIMES = 5'h12;
  localparam logic [5:0] BLANK_SYMBOLS = 6'h20;
  localparam logic [4:0] MGMT_ENTRY_CLOCKS = 5'h11;
  localparam logic [1:0] SLIP_RUN_LAST = 2'h2;
  localparam logic [3:0] NACK_ZERO_CLOCKS = 4'h9;
  localparam logic [3:0] NACK_TOTAL_CLOCKS = 4'hA;

  // Receive symbol codes, MAC mode.
  localparam logic [2:0] RX_ZERO = 3'h0;
  localparam logic [2:0] RX_ONE = 3'h1;
  localparam logic [2:0] RX_NONDATA = 3'h4;
  localparam logic [2:0] RX_SILENCE = 3'h6;
  localparam logic [2:0] RX_BAD = 3'h2;

  // Receive symbol codes, management mode.
  localparam logic [2:0] MG_NACK = 3'h4;
  localparam logic [2:0] MG_ACK = 3'h2;
  localparam logic [2:0] MG_IDLE = 3'h1;
  localparam logic [2:0] MG_ERROR = 3'h7;

  // Request channel commands in management mode, and MAC-mode silence request.
  localparam logic [2:0] CMD_RESET = 3'h7;
  localparam logic [2:0] CMD_NO_LOOP = 3'h5;
  localparam logic [2:0] CMD_TX_EN = 3'h3;
  localparam logic [1:0] CMD_SERIAL_HI = 2'h0;
  localparam logic [1:0] TX_SILENCE_HI = 2'h3;

  typedef enum logic [1:0] {
    SYM_ONE = 2'b00,
    SYM_ZERO = 2'b01,
    SYM_ND1 = 2'b10,
    SYM_ND2 = 2'b11
  } fsr_class_t;

  typedef enum logic [1:0] {
    MS_MAC = 2'b00,
    MS_ENTRY = 2'b01,
    MS_MGMT = 2'b10,
    MS_WAIT_MAC = 2'b11
  } fsr_mgmt_t;

endpackage

// ---- hw/fsr_symbol_recovery.sv ----
`timescale 1ns/1ps
module fsr_symbol_recovery (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic limited_rx_signal_i,
  input wire logic loop_tx_signal_i,
  input wire logic carrier_detect_i,
  input wire logic jabber_error_i,
  input wire logic tx_symbol_clock_i,
  input wire logic mgmt_request_n_i,
  input wire logic tx_sym_bit2_i,
  input wire logic tx_sym_bit1_i,
  input wire logic tx_sym_bit0_i,
  input wire logic blanking_disable_n_i,
  output logic recovered_rx_clock_o,
  output logic rx_sym_bit2_o,
  output logic rx_sym_bit1_o,
  output logic rx_sym_bit0_o,
  output logic mgmt_indication_n_o,
  output logic loopback_active_o,
  output logic tx_enable_o
);
  import fsr_pkg::*;

  // All pin inputs pass two flip-flops; a third stage serves edge detection only.
  logic [9:0] pin_raw;
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  logic [9:0] sync3_ff;
  assign pin_raw = {limited_rx_signal_i, loop_tx_signal_i, carrier_detect_i, jabber_error_i, tx_symbol_clock_i,
                    mgmt_request_n_i, tx_sym_bit2_i, tx_sym_bit1_i, tx_sym_bit0_i, blanking_disable_n_i};
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Reset values match the idle pin levels, so no false edge or jabber follows reset.
      sync1_ff <= 10'h01D;
      sync2_ff <= 10'h01D;
      sync3_ff <= 10'h01D;
    end else begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic rx_sig;
  logic rx_sig_prev;
  logic loop_sig;
  logic loop_sig_prev;
  logic pin_carrier;
  logic jabber;
  logic tx_symbol_clock;
  logic tx_rise;
  logic req_n;
  logic [2:0] txsym;
  logic blank_en;
  assign rx_sig = sync2_ff[9];
  assign rx_sig_prev = sync3_ff[9];
  assign loop_sig = sync2_ff[8];
  assign loop_sig_prev = sync3_ff[8];
  assign pin_carrier = sync2_ff[7];
  assign jabber = sync2_ff[6];
  assign tx_symbol_clock = sync2_ff[5];
  assign tx_rise = sync2_ff[5] & ~sync3_ff[5];
  assign req_n = sync2_ff[4];
  assign txsym = sync2_ff[3:1];
  assign blank_en = sync2_ff[0];

  // Management request channel, sampled on transmit clock rising edges.
  fsr_mgmt_t mstate_ff, nxt_mstate;
  logic [4:0] entry_cnt_ff, nxt_entry_cnt;
  logic [3:0] nack_cnt_ff, nxt_nack_cnt;
  logic [2:0] mg_sym_ff, nxt_mg_sym;
  logic loop_ff, nxt_loop;
  logic txen_ff, nxt_txen;
  logic [LEN_W-1:0] per_cnt_ff, nxt_per_cnt;
  logic [LEN_W-1:0] bit_len_ff, nxt_bit_len;

  always_comb begin
    nxt_mstate = mstate_ff;
    nxt_entry_cnt = entry_cnt_ff;
    nxt_nack_cnt = nack_cnt_ff;
    nxt_mg_sym = mg_sym_ff;
    nxt_loop = loop_ff;
    nxt_txen = txen_ff;
    nxt_per_cnt = (per_cnt_ff == BIT_LEN_MAX) ? per_cnt_ff : per_cnt_ff + 8'h01;
    nxt_bit_len = bit_len_ff;
    if (tx_rise) begin
      // The local bit period is taken from the transmit clock.
      nxt_per_cnt = 8'h01;
      if (per_cnt_ff > 8'h03) begin
        nxt_bit_len = per_cnt_ff;
      end
      unique case (mstate_ff)
        MS_WAIT_MAC: begin
          if (req_n) begin
            nxt_mstate = MS_MAC;
          end
        end
        MS_MAC: begin
          if (!req_n) begin
            nxt_mstate = MS_ENTRY;
            nxt_entry_cnt = 5'h01;
          end
        end
        MS_ENTRY: begin
          if (req_n) begin
            nxt_mstate = MS_MAC;
          end else if (entry_cnt_ff == MGMT_ENTRY_CLOCKS) begin
            nxt_mstate = MS_MGMT;
            nxt_mg_sym = MG_IDLE;
            nxt_nack_cnt = 4'h0;
          end else begin
            nxt_entry_cnt = entry_cnt_ff + 5'h01;
          end
        end
        MS_MGMT: begin
          if (req_n) begin
            nxt_mstate = MS_MAC;
            nxt_nack_cnt = 4'h0;
          end else if (txsym == CMD_RESET || txsym == CMD_NO_LOOP || txsym == CMD_TX_EN) begin
            // These commands also abort a running nack byte.
            nxt_mg_sym = MG_ACK;
            nxt_nack_cnt = 4'h0;
            if (txsym == CMD_RESET) begin
              nxt_loop = 1'b1;
              nxt_txen = 1'b0;
            end else if (txsym == CMD_NO_LOOP) begin
              nxt_loop = 1'b0;
            end else begin
              nxt_txen = 1'b1;
            end
          end else if (nack_cnt_ff != 4'h0) begin
            // Start bit and eight zero bits, then a stop bit.
            nxt_nack_cnt = (nack_cnt_ff == NACK_TOTAL_CLOCKS) ? 4'h0 : nack_cnt_ff + 4'h1;
            nxt_mg_sym = (nack_cnt_ff == NACK_TOTAL_CLOCKS) ? MG_IDLE :
                         (nack_cnt_ff >= NACK_ZERO_CLOCKS) ? (MG_NACK | 3'h1) : MG_NACK;
          end else if (txsym == {CMD_SERIAL_HI, 1'b0}) begin
            nxt_mg_sym = MG_NACK;
            nxt_nack_cnt = 4'h1;
          end else begin
            nxt_mg_sym = MG_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mstate_ff <= MS_WAIT_MAC;
      entry_cnt_ff <= 5'h00;
      nack_cnt_ff <= 4'h0;
      mg_sym_ff <= MG_IDLE;
      loop_ff <= 1'b1;
      txen_ff <= 1'b0;
      per_cnt_ff <= 8'h00;
      bit_len_ff <= BIT_LEN_RESET;
    end else begin
      mstate_ff <= nxt_mstate;
      entry_cnt_ff <= nxt_entry_cnt;
      nack_cnt_ff <= nxt_nack_cnt;
      mg_sym_ff <= nxt_mg_sym;
      loop_ff <= nxt_loop;
      txen_ff <= nxt_txen;
      per_cnt_ff <= nxt_per_cnt;
      bit_len_ff <= nxt_bit_len;
    end
  end

  // Data recovery.
  logic [LEN_W-1:0] phase_ff, nxt_phase;
  logic carrier;
  logic edge_seen;
  logic [LEN_W-1:0] eighth;
  logic bit_end;
  logic in_q1;
  logic in_q3;
  assign carrier = loop_ff ? (txsym[2:1] != TX_SILENCE_HI) : pin_carrier;
  assign edge_seen = loop_ff ? (loop_sig ^ loop_sig_prev) : (rx_sig ^ rx_sig_prev);
  assign eighth = bit_len_ff >> 3;
  assign bit_end = (phase_ff >= bit_len_ff - 8'h01);
  assign in_q1 = (phase_ff >= eighth) && (phase_ff < (bit_len_ff >> 2) + eighth);
  assign in_q3 = (phase_ff >= (bit_len_ff >> 1) + eighth) && (phase_ff < bit_len_ff - eighth);

  logic q1_ff, nxt_q1;
  logic q3_ff, nxt_q3;
  logic carrier_prev_ff, nxt_carrier_prev;
  logic align_ff, nxt_align;
  logic skip_ff, nxt_skip;
  logic [4:0] train_ff, nxt_train;
  logic [5:0] blank_ff, nxt_blank;
  logic [1:0] nd_run_ff, nxt_nd_run;
  logic [15:0] hist_ff, nxt_hist;
  logic [2:0] mac_sym_ff, nxt_mac_sym;
  fsr_class_t cls;
  fsr_class_t prev_cls;

  function automatic logic is_nd(input logic [1:0] c);
    is_nd = c[1];
  endfunction

  always_comb begin
    nxt_phase = bit_end ? 8'h00 : phase_ff + 8'h01;
    nxt_q1 = q1_ff | (edge_seen & in_q1);
    nxt_q3 = q3_ff | (edge_seen & in_q3);
    nxt_carrier_prev = carrier;
    nxt_align = align_ff;
    nxt_skip = skip_ff;
    nxt_train = train_ff;
    nxt_blank = blank_ff;
    nxt_nd_run = nd_run_ff;
    nxt_hist = hist_ff;
    nxt_mac_sym = mac_sym_ff;
    prev_cls = fsr_class_t'(hist_ff[1:0]);
    unique case ({q1_ff, q3_ff})
      2'b00: cls = SYM_ONE;
      2'b11: cls = SYM_ZERO;
      2'b10: cls = SYM_ND1;
      2'b01: cls = SYM_ND2;
    endcase
    if (carrier && !carrier_prev_ff) begin
      nxt_train = TRAIN_BIT_TIMES;
      nxt_align = 1'b1;
    end
    if (align_ff && edge_seen) begin
      // The first received edge marks a bit boundary.
      nxt_phase = 8'h01;
      nxt_align = 1'b0;
      nxt_q1 = 1'b0;
      nxt_q3 = 1'b0;
    end else if (bit_end) begin
      nxt_q1 = 1'b0;
      nxt_q3 = 1'b0;
      if (train_ff != 5'h00) begin
        nxt_train = train_ff - 5'h01;
      end
      if (blank_ff != 6'h00) begin
        nxt_blank = blank_ff - 6'h01;
      end
      if (!carrier) begin
        nxt_hist = 16'h0000;
        nxt_nd_run = 2'h0;
        nxt_skip = 1'b0;
        nxt_mac_sym = RX_SILENCE;
      end else if (skip_ff) begin
        // The shortened period after a slip is discarded, not reported.
        nxt_skip = 1'b0;
        nxt_mac_sym = RX_SILENCE;
      end else if (is_nd(cls) && nd_run_ff == SLIP_RUN_LAST) begin
        nxt_phase = bit_len_ff >> 1;
        nxt_skip = 1'b1;
        nxt_nd_run = 2'h0;
        nxt_hist = 16'h0000;
        nxt_mac_sym = RX_SILENCE;
      end else begin
        nxt_nd_run = is_nd(cls) ? nd_run_ff + 2'h1 : 2'h0;
        nxt_hist = {hist_ff[13:0], cls};
        if ((prev_cls == SYM_ND1 && cls != SYM_ND2) || (prev_cls != SYM_ND1 && cls == SYM_ND2)) begin
          nxt_mac_sym = RX_BAD;
        end else if (is_nd(cls)) begin
          nxt_mac_sym = RX_NONDATA;
        end else begin
          nxt_mac_sym = (cls == SYM_ONE) ? RX_ONE : RX_ZERO;
        end
        if (train_ff != 5'h00 || blank_ff != 6'h00) begin
          nxt_mac_sym = RX_SILENCE;
        end
        // End delimiter N N 1 N N 1 I E with I equal to zero is the last one.
        if (hist_ff[13] && hist_ff[11] && hist_ff[9:8] == SYM_ONE && hist_ff[7] && hist_ff[5]
            && hist_ff[3:2] == SYM_ONE && hist_ff[1:0] == SYM_ZERO && !is_nd(cls)) begin
          nxt_blank = blank_en ? BLANK_SYMBOLS : 6'h00;
          nxt_hist = 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_ff <= 8'h00;
      q1_ff <= 1'b0;
      q3_ff <= 1'b0;
      carrier_prev_ff <= 1'b0;
      align_ff <= 1'b0;
      skip_ff <= 1'b0;
      train_ff <= 5'h00;
      blank_ff <= 6'h00;
      nd_run_ff <= 2'h0;
      hist_ff <= 16'h0000;
      mac_sym_ff <= RX_SILENCE;
    end else begin
      phase_ff <= nxt_phase;
      q1_ff <= nxt_q1;
      q3_ff <= nxt_q3;
      carrier_prev_ff <= nxt_carrier_prev;
      align_ff <= nxt_align;
      skip_ff <= nxt_skip;
      train_ff <= nxt_train;
      blank_ff <= nxt_blank;
      nd_run_ff <= nxt_nd_run;
      hist_ff <= nxt_hist;
      mac_sym_ff <= nxt_mac_sym;
    end
  end

  // Indication channel outputs, all registered.
  logic recovered_rx_clock_ff, nxt_recovered_rx_clock;
  logic [2:0] rx_sym_ff, nxt_rx_sym;
  logic ind_n_ff, nxt_ind_n;
  logic mgmt_side;
  assign mgmt_side = (mstate_ff == MS_MGMT) || (mstate_ff == MS_ENTRY);

  always_comb begin
    // In management mode the receive clock follows the transmit clock.
    nxt_recovered_rx_clock = mgmt_side ? tx_symbol_clock : (phase_ff < (bit_len_ff >> 1));
    nxt_rx_sym = rx_sym_ff;
    nxt_ind_n = ind_n_ff;
    if (jabber) begin
      nxt_rx_sym = MG_ERROR;
      nxt_ind_n = 1'b0;
    end else if (mstate_ff == MS_MGMT) begin
      nxt_rx_sym = mg_sym_ff;
      nxt_ind_n = 1'b0;
    end else if (mstate_ff == MS_ENTRY) begin
      nxt_rx_sym = RX_SILENCE;
      nxt_ind_n = 1'b1;
    end else if (phase_ff == 8'h00) begin
      nxt_rx_sym = mac_sym_ff;
      nxt_ind_n = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      recovered_rx_clock_ff <= 1'b0;
      rx_sym_ff <= RX_SILENCE;
      ind_n_ff <= 1'b1;
    end else begin
      recovered_rx_clock_ff <= nxt_recovered_rx_clock;
      rx_sym_ff <= nxt_rx_sym;
      ind_n_ff <= nxt_ind_n;
    end
  end

  assign recovered_rx_clock_o = recovered_rx_clock_ff;
  assign rx_sym_bit2_o = rx_sym_ff[2];
  assign rx_sym_bit1_o = rx_sym_ff[1];
  assign rx_sym_bit0_o = rx_sym_ff[0];
  assign mgmt_indication_n_o = ind_n_ff;
  assign loopback_active_o = loop_ff;
  assign tx_enable_o = txen_ff;

endmodule

// ---- dv/fsr_mac_model.sv ----
`timescale 1ns/1ps
// Controller side of the request channel: makes the transmit clock and drives the symbol lines.
module fsr_mac_model (
  input wire logic clock_i,
  output logic tx_symbol_clock_o,
  output logic mgmt_request_n_o,
  output logic [2:0] tx_sym_o
);
  // The transmit clock is crystal derived and runs free at 8 MHz, offset from the system clock edges.
  initial begin
    tx_symbol_clock_o = 1'b0;
    mgmt_request_n_o = 1'b1;
    tx_sym_o = 3'h6;
    #1;
    forever #62.5 tx_symbol_clock_o = ~tx_symbol_clock_o;
  end
  // Lines change only after a transmit clock fall, so they are settled at the next rise.
  task automatic send(input logic req_n, input logic [2:0] sym);
    @(negedge tx_symbol_clock_o);
    @(negedge clock_i);
    mgmt_request_n_o <= req_n;
    tx_sym_o <= sym;
  endtask
  task automatic wait_rises(input int n);
    repeat (n) @(posedge tx_symbol_clock_o);
  endtask
endmodule

// ---- dv/fsr_symbol_recovery_chk.sv ----
`timescale 1ns/1ps
module fsr_symbol_recovery_chk
  import fsr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic limited_rx_signal_i,
  input wire logic loop_tx_signal_i,
  input wire logic carrier_detect_i,
  input wire logic jabber_error_i,
  input wire logic tx_symbol_clock_i,
  input wire logic mgmt_request_n_i,
  input wire logic tx_sym_bit2_i,
  input wire logic tx_sym_bit1_i,
  input wire logic tx_sym_bit0_i,
  input wire logic blanking_disable_n_i,
  input wire logic recovered_rx_clock_o,
  input wire logic rx_sym_bit2_o,
  input wire logic rx_sym_bit1_o,
  input wire logic rx_sym_bit0_o,
  input wire logic mgmt_indication_n_o,
  input wire logic loopback_active_o,
  input wire logic tx_enable_o
);
  logic [9:0] low_ff, nxt_low;
  logic [7:0] quiet_ff, nxt_quiet, cmd_ff, nxt_cmd;
  logic [2:0] tx, rx;
  logic silent_src, cmd_on;
  // Counters of cycles spent requesting management, silent at the source, and holding an acked command.
  always_comb begin
    tx = {tx_sym_bit2_i, tx_sym_bit1_i, tx_sym_bit0_i};
    rx = {rx_sym_bit2_o, rx_sym_bit1_o, rx_sym_bit0_o};
    silent_src = loopback_active_o ? (tx_sym_bit2_i & tx_sym_bit1_i) : !carrier_detect_i;
    cmd_on = !mgmt_indication_n_o && !mgmt_request_n_i && !jabber_error_i && tx_sym_bit0_i && (tx[2] | tx[1]);
    nxt_low = mgmt_request_n_i ? 10'h000 : low_ff + {9'h000, ~&low_ff};
    nxt_quiet = (silent_src && mgmt_indication_n_o && !jabber_error_i) ? quiet_ff + {7'h00, ~&quiet_ff} : 8'h00;
    nxt_cmd = cmd_on ? cmd_ff + {7'h00, ~&cmd_ff} : 8'h00;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_ff <= 10'h000;
      quiet_ff <= 8'h00;
      cmd_ff <= 8'h00;
    end else begin
      low_ff <= nxt_low;
      quiet_ff <= nxt_quiet;
      cmd_ff <= nxt_cmd;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_serial_mgmt_data_cmd;
    !mgmt_indication_n_o && !mgmt_request_n_i && !jabber_error_i && tx == 3'h0 && $past(tx) != 3'h0;
  endsequence
  sequence s_nack_low;
    (rx == MG_NACK) [*8];
  endsequence
  property p_nack;
    s_serial_mgmt_data_cmd |-> ##[1:60] s_nack_low;
  endproperty
  a_nack: assert property (p_nack) else $error("serial command not answered by nack");
  property p_jabber;
    jabber_error_i [*8] |-> ##[0:80] (rx == MG_ERROR && !mgmt_indication_n_o);
  endproperty
  a_jabber: assert property (p_jabber) else $error("jabber did not force the error code");
  property p_sym_clk;
    $changed(rx) && mgmt_indication_n_o && $past(mgmt_indication_n_o) && !jabber_error_i
      && !$past(jabber_error_i, 6) |-> $rose(recovered_rx_clock_o);
  endproperty
  a_sym_clk: assert property (p_sym_clk) else $error("receive symbol moved off the receive clock");
  property p_mac_return;
    $rose(mgmt_request_n_i) && !jabber_error_i |-> ##[1:60] (mgmt_indication_n_o || jabber_error_i);
  endproperty
  a_mac_return: assert property (p_mac_return) else $error("indication not high after mac request");
  property p_entry_early;
    $fell(mgmt_indication_n_o) && !jabber_error_i |-> low_ff >= 10'h190;
  endproperty
  a_entry_early: assert property (p_entry_early) else $error("management entered too early");
  property p_entry_late;
    low_ff == 10'h1F4 && !jabber_error_i |-> !mgmt_indication_n_o;
  endproperty
  a_entry_late: assert property (p_entry_late) else $error("management not entered in time");
  property p_quiet;
    quiet_ff >= 8'h50 |-> rx == RX_SILENCE;
  endproperty
  a_quiet: assert property (p_quiet) else $error("symbols reported without carrier");
  property p_ack;
    cmd_ff == 8'h50 |-> rx == MG_ACK;
  endproperty
  a_ack: assert property (p_ack) else $error("command not acknowledged in time");
  property p_reset_cmd;
    cmd_ff == 8'h50 && tx == CMD_RESET |-> loopback_active_o && !tx_enable_o;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command left wrong modes");
endmodule

// ---- dv/fsr_symbol_recovery_test.sv ----
`timescale 1ns/1ps
module fsr_symbol_recovery_test;
  import fsr_pkg::*;
  logic clock_i, rst_b_i, wave, carrier, jabber, blank_n;
  // Final end delimiter: N N 1 N N 1, intermediate bit zero, then a data bit.
  logic [3:0] dlm[8] = '{4'h7, 4'hD, 4'h5, 4'h7, 4'hD, 4'h5, 4'hF, 4'h5};
  wire logic tx_clk, req_n, rx_clk, ind_n, loop_on, tx_en;
  wire logic [2:0] tx_sym, rx;
  int fails, checked;
  logic [2:0] seen[$];
  // Command, expected answer, loopback and transmitter state after it.
  logic [7:0] tab[6] = '{8'hA8, 8'h69, 8'hEA, 8'hA8, 8'h10, 8'hC4};
  // Edge masks at 0, 1/4, 1/2 and 3/4 of a bit: one, zero, first and second non-data types.
  logic [3:0] pat[7] = '{4'h5, 4'hF, 4'h7, 4'hD, 4'hF, 4'hD, 4'h5};
  logic [2:0] want[7] = '{RX_ONE, RX_ZERO, RX_NONDATA, RX_NONDATA, RX_ZERO, RX_BAD, RX_ONE};
  fsr_mac_model mac (.clock_i(clock_i), .tx_symbol_clock_o(tx_clk), .mgmt_request_n_o(req_n), .tx_sym_o(tx_sym));
  fsr_symbol_recovery DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .limited_rx_signal_i(wave),
    .loop_tx_signal_i(wave), .carrier_detect_i(carrier), .jabber_error_i(jabber), .tx_symbol_clock_i(tx_clk),
    .mgmt_request_n_i(req_n), .tx_sym_bit2_i(tx_sym[2]), .tx_sym_bit1_i(tx_sym[1]), .tx_sym_bit0_i(tx_sym[0]),
    .blanking_disable_n_i(blank_n), .recovered_rx_clock_o(rx_clk), .rx_sym_bit2_o(rx[2]), .rx_sym_bit1_o(rx[1]),
    .rx_sym_bit0_o(rx[0]), .mgmt_indication_n_o(ind_n), .loopback_active_o(loop_on), .tx_enable_o(tx_en));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(negedge rx_clk) if (ind_n === 1'b1) seen.push_back(rx);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: seen 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One bit of 25 system clocks, matching the measured transmit clock period.
  task automatic send_bit(input logic [3:0] edges);
    for (int q = 0; q < 4; q++) begin
      if (edges[q]) wave <= ~wave;
      repeat (q == 3 ? 7 : 6) @(negedge clock_i);
    end
  endtask
  task automatic stream(input string name);
    logic hit;
    logic ok;
    seen.delete();
    hit = 1'b0;
    repeat (8) @(negedge clock_i);
    repeat (20) send_bit(4'h5);
    foreach (pat[i]) send_bit(pat[i]);
    repeat (3) send_bit(4'h5);
    for (int i = 0; i + 7 <= seen.size(); i++) begin
      ok = 1'b1;
      for (int j = 0; j < 7; j++) if (seen[i + j] !== want[j]) ok = 1'b0;
      hit = hit | ok;
    end
    check({7'h00, hit}, 8'h01);
    $display("test %s done", name);
  endtask
  task automatic eot(input logic [2:0] last);
    foreach (dlm[i]) send_bit(dlm[i]);
    repeat (6) send_bit(4'h5);
    check({5'h00, seen[seen.size() - 1]}, {5'h00, last});
  endtask
  task automatic settle();
    mac.wait_rises(2);
    repeat (5) @(negedge clock_i);
  endtask
  initial begin
    rst_b_i = 1'b0;
    wave = 1'b0;
    carrier = 1'b0;
    jabber = 1'b0;
    blank_n = 1'b1;
    fails = 0;
    checked = 0;
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    check({5'h00, rx}, {5'h00, RX_SILENCE});
    check({5'h00, ind_n, loop_on, tx_en}, 8'h06);
    mac.send(1'b1, 3'h0);
    mac.wait_rises(1);
    stream("loopback decode");
    mac.send(1'b1, 3'h6);
    repeat (4) send_bit(4'h5);
    check({5'h00, rx}, {5'h00, RX_SILENCE});
    mac.send(1'b0, 3'h1);
    for (int n = 0; n < 30 && ind_n !== 1'b0; n++) @(posedge tx_clk);
    check({7'h00, ind_n}, 8'h00);
    foreach (tab[k]) begin
      mac.send(1'b0, tab[k][7:5]);
      settle();
      check({5'h00, rx}, {5'h00, tab[k][4:2]});
      check({6'h00, loop_on, tx_en}, {6'h00, tab[k][1:0]});
      mac.send(1'b0, 3'h1);
      mac.wait_rises(13);
      check({5'h00, rx}, {5'h00, MG_IDLE});
    end
    $display("test management done");
    mac.send(1'b1, 3'h6);
    settle();
    mac.wait_rises(1);
    check({7'h00, ind_n}, 8'h01);
    repeat (4) send_bit(4'h5);
    check({5'h00, rx}, {5'h00, RX_SILENCE});
    carrier = 1'b1;
    stream("external decode");
    eot(RX_SILENCE);
    repeat (30) send_bit(4'h5);
    blank_n = 1'b0;
    eot(RX_ONE);
    blank_n = 1'b1;
    $display("test blanking done");
    jabber = 1'b1;
    repeat (100) @(negedge clock_i);
    check({4'h0, rx, ind_n}, {4'h0, MG_ERROR, 1'b0});
    jabber = 1'b0;
    $display("test jabber done");
    final_report();
  end
  initial begin
    #60000;
    fails++;
    final_report();
  end
endmodule
bind fsr_symbol_recovery fsr_symbol_recovery_chk chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .limited_rx_signal_i(limited_rx_signal_i), .loop_tx_signal_i(loop_tx_signal_i),
  .carrier_detect_i(carrier_detect_i), .jabber_error_i(jabber_error_i), .tx_symbol_clock_i(tx_symbol_clock_i),
  .mgmt_request_n_i(mgmt_request_n_i), .tx_sym_bit2_i(tx_sym_bit2_i), .tx_sym_bit1_i(tx_sym_bit1_i),
  .tx_sym_bit0_i(tx_sym_bit0_i), .blanking_disable_n_i(blanking_disable_n_i),
  .recovered_rx_clock_o(recovered_rx_clock_o), .rx_sym_bit2_o(rx_sym_bit2_o), .rx_sym_bit1_o(rx_sym_bit1_o),
  .rx_sym_bit0_o(rx_sym_bit0_o), .mgmt_indication_n_o(mgmt_indication_n_o),
  .loopback_active_o(loopback_active_o), .tx_enable_o(tx_enable_o));
